// *** rtl/msl_defs.vh ***
// Constants for the motion module status LED block
`ifndef MSL_DEFS_VH
`define MSL_DEFS_VH
`define MSL_CLK_HZ 20000000
`define MSL_SLOW_HZ 4
`define MSL_FAST_HZ 8
`define MSL_BOOT_HZ 2
`define MSL_CODE_W 8
`define MSL_CODE_IDX_W 2
`define MSL_NUM_WORDS 4
`define MSL_BAUD_MIN 16'h012c
`define MSL_BAUD_MAX 16'h4b00
`define MSL_BAUD_DEF 16'h4b00
`define MSL_BLINK_MAX 4'hf
`define MSL_PAUSE_HALVES 4'h4
`define MSL_GAP_HALVES 4'h8
`endif

// *** rtl/msl_blink_div.v ***
// Free-running divider giving square-wave flash phases
`timescale 1ns/10ps
`include "msl_defs.vh"
module msl_blink_div #(
   parameter integer CLK_HZ = `MSL_CLK_HZ,
   parameter integer SLOW_HZ = `MSL_SLOW_HZ,
   parameter integer FAST_HZ = `MSL_FAST_HZ,
   parameter integer BOOT_HZ = `MSL_BOOT_HZ
) (
   input wire clk_i,
   input wire reset_n_i,
   output wire fast_o,
   output wire slow_o,
   output wire boot_o,
   output wire fast_tick_o
);
   // Half period of the fast rate; slower rates are binary multiples
   localparam integer HALF = CLK_HZ / (2 * FAST_HZ);
   localparam integer SLOW_DIV = FAST_HZ / SLOW_HZ;
   localparam integer BOOT_DIV = FAST_HZ / BOOT_HZ;
   reg [23:0] cnt_r;
   reg [7:0] phase_r;
   wire wrap = (cnt_r == HALF[23:0] - 24'h1);
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= 24'h0;
         phase_r <= 8'h0;
      end else if (wrap) begin
         cnt_r <= 24'h0;
         phase_r <= phase_r + 8'h1;
      end else begin
         cnt_r <= cnt_r + 24'h1;
      end
   end
   // R16 common divider phases
   assign fast_o = ~phase_r[0];
   assign slow_o = ~phase_r[$clog2(SLOW_DIV)];
   assign boot_o = ~phase_r[$clog2(BOOT_DIV)];
   assign fast_tick_o = wrap;
endmodule

// *** rtl/msl_status_leds.v ***
// Front-panel status LED logic for a two-servo-axis motion module
// Notes on behaviour
// R1: With configuration lit and a status-only error, status LED flashes four times a second.
// R2: With a servo-stopping error, status LED flashes eight times a second.
// R3: An operational error puts its code in one of four status words and raises the error bit.
// R4: In boot mode status and configuration LEDs flash together at a constant rate.
// R5: After a watchdog timeout status and configuration LEDs flash alternately at a constant rate.
// R6: A power-up fault blinks the status LED in two counted groups with a pause, configuration off.
// R7: Status LED is steady on in correct operation and off when power-up cannot complete.
// R8: Health LED is steady on when working and off when power-up is prevented.
// R9: Configuration LED lights once a valid configuration has been received.
// R10: During a program store the configuration LED flashes four times a second.
// R11: During an EEPROM write the configuration LED flashes eight times a second.
// R12: Axis 1 and 2 LEDs follow their servo drive enables exactly.
// R13: Aux 3 and 4 LEDs follow their forced analog output commands exactly.
// R14: Serial port bit rate is configurable from 300 to 19200 baud.
// R15: Both servo axes always run the same control type, analog or digital.
// R16: All flash patterns come from one free-running divider with equal on and off times.
`timescale 1ns/10ps
`include "msl_defs.vh"
module msl_status_leds #(
   parameter integer CLK_HZ = `MSL_CLK_HZ,
   parameter integer CODE_W = `MSL_CODE_W
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire hw_ok_i,
   input wire powerup_fault_i,
   input wire [3:0] fault_num_a_i,
   input wire [3:0] fault_num_b_i,
   input wire boot_mode_i,
   input wire watchdog_to_i,
   input wire config_valid_i,
   input wire status_err_i,
   input wire stop_err_i,
   input wire err_log_i,
   input wire [1:0] err_word_i,
   input wire [CODE_W-1:0] err_code_i,
   input wire clear_err_i,
   input wire prog_store_i,
   input wire eeprom_write_i,
   input wire [1:0] drive_en_i,
   input wire [1:0] force_out_i,
   input wire [15:0] baud_cfg_i,
   input wire servo_digital_i,
   output reg status_led_o,
   output reg health_led_o,
   output reg config_led_o,
   output reg axis1_drive_led_o,
   output reg axis2_drive_led_o,
   output reg aux3_force_out_led_o,
   output reg aux4_force_out_led_o,
   output reg [4*CODE_W-1:0] status_words_o,
   output reg module_err_o,
   output reg [15:0] serial_port_baud_o,
   output reg baud_cfg_err_o,
   output reg servo_digital_o
);
   // Every pin input passes two flops first
   localparam integer NS = 26;
   wire [NS-1:0] raw_in = {hw_ok_i, powerup_fault_i, fault_num_a_i, fault_num_b_i, boot_mode_i,
      watchdog_to_i, config_valid_i, status_err_i, stop_err_i, err_log_i, clear_err_i,
      prog_store_i, eeprom_write_i, drive_en_i, force_out_i, servo_digital_i, err_word_i};
   reg [NS-1:0] sync1_r;
   reg [NS-1:0] sync2_r;
   reg [CODE_W-1:0] code1_r;
   reg [CODE_W-1:0] code2_r;
   reg [15:0] baud1_r;
   reg [15:0] baud2_r;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_r <= {NS{1'b0}};
         sync2_r <= {NS{1'b0}};
         code1_r <= {CODE_W{1'b0}};
         code2_r <= {CODE_W{1'b0}};
         baud1_r <= 16'h0;
         baud2_r <= 16'h0;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
         code1_r <= err_code_i;
         code2_r <= code1_r;
         baud1_r <= baud_cfg_i;
         baud2_r <= baud1_r;
      end
   end
   wire s_hw_ok = sync2_r[25];
   wire s_pu_fault = sync2_r[24];
   wire [3:0] s_num_a = sync2_r[23:20];
   wire [3:0] s_num_b = sync2_r[19:16];
   wire s_boot = sync2_r[15];
   wire s_wdog = sync2_r[14];
   wire s_cfg = sync2_r[13];
   wire s_stat_err = sync2_r[12];
   wire s_stop_err = sync2_r[11];
   wire s_err_log = sync2_r[10];
   wire s_clear = sync2_r[9];
   wire s_store = sync2_r[8];
   wire s_eeprom = sync2_r[7];
   wire [1:0] s_drive = sync2_r[6:5];
   wire [1:0] s_force = sync2_r[4:3];
   wire s_digital = sync2_r[2];
   wire [1:0] s_word = sync2_r[1:0];

   wire ph_fast;
   wire ph_slow;
   wire ph_boot;
   wire half_tick;
   // R16 shared flash divider
   msl_blink_div #(
      .CLK_HZ(CLK_HZ)
   ) u_div (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .fast_o(ph_fast),
      .slow_o(ph_slow),
      .boot_o(ph_boot),
      .fast_tick_o(half_tick)
   );

   // Power-up fault blink sequencer, one-hot
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_GRP_A = 5'h02;
   localparam [4:0] ST_PAUSE = 5'h04;
   localparam [4:0] ST_GRP_B = 5'h08;
   localparam [4:0] ST_GAP = 5'h10;
   reg [4:0] st_r;
   reg [4:0] st_nxt;
   reg [4:0] half_r;
   reg [4:0] half_nxt;
   reg [3:0] wait_r;
   reg [3:0] wait_nxt;
   // Blink count uses pairs of fast half periods: on then off
   always @* begin
      st_nxt = st_r;
      half_nxt = half_r;
      wait_nxt = wait_r;
      case (st_r)
         ST_IDLE: begin
            if (s_pu_fault) begin
               st_nxt = ST_GRP_A;
               half_nxt = 5'h0;
            end
         end
         ST_GRP_A: begin
            if (half_tick) begin
               half_nxt = half_r + 5'h1;
               if (half_r[4:1] == s_num_a - 4'h1 && half_r[0]) begin
                  st_nxt = ST_PAUSE;
                  wait_nxt = 4'h0;
               end
            end
         end
         ST_PAUSE: begin
            if (half_tick) begin
               wait_nxt = wait_r + 4'h1;
               if (wait_r == `MSL_PAUSE_HALVES - 4'h1) begin
                  st_nxt = ST_GRP_B;
                  half_nxt = 5'h0;
               end
            end
         end
         ST_GRP_B: begin
            if (half_tick) begin
               half_nxt = half_r + 5'h1;
               if (half_r[4:1] == s_num_b - 4'h1 && half_r[0]) begin
                  st_nxt = ST_GAP;
                  wait_nxt = 4'h0;
               end
            end
         end
         ST_GAP: begin
            if (half_tick) begin
               wait_nxt = wait_r + 4'h1;
               if (wait_r == `MSL_GAP_HALVES - 4'h1) begin
                  st_nxt = s_pu_fault ? ST_GRP_A : ST_IDLE;
                  half_nxt = 5'h0;
               end
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
      // Fault withdrawn: drop back at once
      if (!s_pu_fault) begin
         st_nxt = ST_IDLE;
      end
   end
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= ST_IDLE;
         half_r <= 5'h0;
         wait_r <= 4'h0;
      end else begin
         st_r <= st_nxt;
         half_r <= half_nxt;
         wait_r <= wait_nxt;
      end
   end
   // R6 counted blink groups
   wire pu_blink = ((st_r == ST_GRP_A) || (st_r == ST_GRP_B)) && !half_r[0];

   // Status words and error bit; set wins over clear
   reg [4*CODE_W-1:0] words_nxt;
   reg err_nxt;
   always @* begin
      words_nxt = status_words_o;
      err_nxt = module_err_o;
      if (s_clear) begin
         err_nxt = 1'b0;
      end
      // R3 error code capture
      if (s_err_log) begin
         words_nxt[s_word*CODE_W +: CODE_W] = code2_r;
         err_nxt = 1'b1;
      end
   end

   // R14 baud range check
   wire baud_ok = (baud2_r >= `MSL_BAUD_MIN) && (baud2_r <= `MSL_BAUD_MAX);

   // LED priority: hardware dead, power-up fault, watchdog, boot, then normal
   reg stat_nxt;
   reg cfg_nxt;
   always @* begin
      stat_nxt = 1'b1;
      cfg_nxt = 1'b0;
      if (!s_hw_ok) begin
         // R7 dead module dark
         stat_nxt = 1'b0;
      end else if (s_pu_fault) begin
         // R6 configuration dark
         stat_nxt = pu_blink;
      end else if (s_wdog) begin
         // R5 antiphase pair
         stat_nxt = ph_boot;
         cfg_nxt = ~ph_boot;
      end else if (s_boot) begin
         // R4 in-phase pair
         stat_nxt = ph_boot;
         cfg_nxt = ph_boot;
      end else begin
         if (s_stop_err) begin
            // R2 fast flash
            stat_nxt = ph_fast;
         end else if (s_stat_err && s_cfg) begin
            // R1 slow flash
            stat_nxt = ph_slow;
         end
         if (s_eeprom) begin
            // R11 fast config flash
            cfg_nxt = ph_fast;
         end else if (s_store) begin
            // R10 slow config flash
            cfg_nxt = ph_slow;
         end else begin
            // R9 configuration received
            cfg_nxt = s_cfg;
         end
      end
   end

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_led_o <= 1'b0;
         health_led_o <= 1'b0;
         config_led_o <= 1'b0;
         axis1_drive_led_o <= 1'b0;
         axis2_drive_led_o <= 1'b0;
         aux3_force_out_led_o <= 1'b0;
         aux4_force_out_led_o <= 1'b0;
         status_words_o <= {4*CODE_W{1'b0}};
         module_err_o <= 1'b0;
         serial_port_baud_o <= `MSL_BAUD_DEF;
         baud_cfg_err_o <= 1'b0;
         servo_digital_o <= 1'b0;
      end else begin
         status_led_o <= stat_nxt;
         // R8 health follows power-up success
         health_led_o <= s_hw_ok && !s_pu_fault;
         config_led_o <= cfg_nxt;
         // R12 drive enables
         axis1_drive_led_o <= s_drive[0];
         axis2_drive_led_o <= s_drive[1];
         // R13 forced outputs
         aux3_force_out_led_o <= s_force[0];
         aux4_force_out_led_o <= s_force[1];
         status_words_o <= words_nxt;
         module_err_o <= err_nxt;
         // R14 out-of-range keeps last good rate
         if (baud_ok) begin
            serial_port_baud_o <= baud2_r;
         end
         baud_cfg_err_o <= !baud_ok;
         // R15 one control type for both axes
         servo_digital_o <= s_digital;
      end
   end
endmodule

// *** testbench/msl_status_leds_checker.sv ***
// Port-level assertions for the status LED block
`timescale 1ns/10ps
module msl_status_leds_checker #(
   parameter integer CODE_W = 8
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire hw_ok_i,
   input wire powerup_fault_i,
   input wire boot_mode_i,
   input wire watchdog_to_i,
   input wire err_log_i,
   input wire [1:0] err_word_i,
   input wire [CODE_W-1:0] err_code_i,
   input wire [1:0] drive_en_i,
   input wire [1:0] force_out_i,
   input wire status_led_o,
   input wire health_led_o,
   input wire config_led_o,
   input wire axis1_drive_led_o,
   input wire axis2_drive_led_o,
   input wire aux3_force_out_led_o,
   input wire aux4_force_out_led_o,
   input wire [4*CODE_W-1:0] status_words_o,
   input wire module_err_o
);
   localparam integer W = CODE_W + 11;
   // Mirrors the two sync flops and the output flop
   reg [W-1:0] p1_r, p2_r, p3_r;
   reg [2:0] live_r;
   wire [W-1:0] in_w = {watchdog_to_i, boot_mode_i, powerup_fault_i, hw_ok_i, force_out_i, drive_en_i, err_log_i,
      err_word_i, err_code_i};
   wire wd3 = p3_r[W-1];
   wire bt3 = p3_r[W-2];
   wire pf3 = p3_r[W-3];
   wire ok3 = p3_r[W-4];
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {live_r, p3_r, p2_r, p1_r} <= {(3 * W + 3){1'b0}};
      end else begin
         {live_r, p3_r, p2_r, p1_r} <= {live_r[1:0], 1'b1, p2_r, p1_r, in_w};
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_axis_drive_follow: assert property (live_r[2] |-> {axis2_drive_led_o, axis1_drive_led_o} == p3_r[W-7:W-8])
      else $error("axis LED off its enable");
   a_aux_force_follow: assert property (live_r[2] |-> {aux4_force_out_led_o, aux3_force_out_led_o} == p3_r[W-5:W-6])
      else $error("aux LED off its command");
   a_health_led_track: assert property (live_r[2] |-> health_led_o == (ok3 && !pf3))
      else $error("health LED wrong");
   a_status_dark_off: assert property (live_r[2] && !ok3 |-> !status_led_o)
      else $error("status LED lit while down");
   a_cfg_fault_off: assert property (live_r[2] && ok3 && pf3 |-> !config_led_o)
      else $error("config LED lit in fault");
   a_boot_in_phase: assert property (live_r[2] && ok3 && !pf3 && !wd3 && bt3 |-> config_led_o == status_led_o)
      else $error("boot flash out of phase");
   a_wd_anti_phase: assert property (live_r[2] && ok3 && !pf3 && wd3 |-> config_led_o != status_led_o)
      else $error("watchdog flash in phase");
   a_err_word_log: assert property (live_r[2] && p3_r[CODE_W+2] |-> module_err_o &&
      status_words_o[p3_r[CODE_W+1:CODE_W]*CODE_W +: CODE_W] == p3_r[CODE_W-1:0]) else $error("error word wrong");
endmodule
bind msl_status_leds msl_status_leds_checker #(.CODE_W(CODE_W)) u_chk (.*);

// *** testbench/msl_panel_watch.sv ***
// Operator view of the status LED, counting blinks per group
`timescale 1ns/10ps
module msl_panel_watch #(
   parameter integer HALF = 100
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire led_i,
   output reg grp_o,
   output reg gap_o,
   output reg [4:0] cnt_o
);
   reg prev_r, armed_r;
   reg [4:0] run_r;
   reg [15:0] off_r;
   // groups split by long dark spells; first group skipped as it may be cut
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {prev_r, armed_r, grp_o, gap_o, cnt_o, run_r, off_r} <= 30'h0;
      end else begin
         prev_r <= led_i;
         grp_o <= 1'b0;
         off_r <= led_i ? 16'h0 : off_r + 16'h1;
         if (led_i && !prev_r && off_r >= 3 * HALF) begin
            grp_o <= armed_r;
            gap_o <= off_r > 6 * HALF;
            cnt_o <= run_r;
            run_r <= 5'h1;
            armed_r <= 1'b1;
         end else if (led_i && !prev_r) begin
            run_r <= run_r + 5'h1;
         end
      end
   end
endmodule

// *** testbench/tb_msl_status_leds.sv ***
// Self-checking bench for the status LED block
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_msl_status_leds;
   logic clk_i = 0, reset_n_i = 0, hw_ok_i = 1, powerup_fault_i = 0, boot_mode_i = 0, watchdog_to_i = 0, err_log_i = 0;
   logic config_valid_i = 1, status_err_i = 0, stop_err_i = 0, clear_err_i = 0, prog_store_i = 0, eeprom_write_i = 0;
   logic servo_digital_i = 0, take = 0, win = 0, merr = 0, berr = 0, ps, pc;
   logic [3:0] fault_num_a_i = 2, fault_num_b_i = 15, ts, tc;
   logic [1:0] err_word_i = 0, drive_en_i = 0, force_out_i = 0;
   logic [7:0] err_code_i = 0;
   logic [15:0] baud_cfg_i = 16'h4b00, be = 16'h4b00;
   logic [31:0] lf = 32'hea34a9e6, wexp = 0;
   logic [115:0] q[$], e;
   logic [5:0] gq[$], g;
   logic [7:0] tq[$];
   logic [13:0] mt[6] = '{14'h2080, 14'h1040, 14'h0822, 14'h0422, 14'h0208, 14'h0104};
   logic [15:0] bt[4] = '{16'd299, 16'd300, 16'd19200, 16'd19201};
   int checks_done = 0, fails = 0, i, n;
   wire status_led_o, health_led_o, config_led_o, axis1_drive_led_o, axis2_drive_led_o, aux3_force_out_led_o;
   wire aux4_force_out_led_o, module_err_o, baud_cfg_err_o, servo_digital_o, grp, gap;
   wire [31:0] status_words_o;
   wire [15:0] serial_port_baud_o;
   wire [4:0] cnt;
   wire [57:0] obs = {status_words_o, serial_port_baud_o, baud_cfg_err_o, servo_digital_o, module_err_o, health_led_o,
      status_led_o, config_led_o, aux4_force_out_led_o, aux3_force_out_led_o, axis2_drive_led_o, axis1_drive_led_o};
   // Small clock rate gives a 100-cycle fast half period
   msl_status_leds #(.CLK_HZ(1600)) dut (.*);
   msl_panel_watch #(.HALF(100)) watch (.clk_i(clk_i), .reset_n_i(reset_n_i), .led_i(status_led_o), .grp_o(grp),
      .gap_o(gap), .cnt_o(cnt));
   initial forever #25 clk_i = ~clk_i;
   function logic [31:0] nx(input logic [31:0] s);
      nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task expect_o(input logic [57:0] m, input logic [57:0] v);
      tick(4);
      q.push_back({m, v});
      take = 1;
      tick(1);
      take = 0;
   endtask
   task do_reset;
      reset_n_i = 0;
      tick(4);
      reset_n_i = 1;
   endtask
   task stop_test;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk_i) begin
      if (take) begin
         e = q.pop_front();
         `CHK(obs & e[115:58], e[57:0] & e[115:58])
      end
      if (grp && gq.size() > 0) begin
         g = gq.pop_front();
         `CHK({gap, cnt}, g)
      end
   end
   // Any 800-cycle window of a square wave holds exactly 800/half toggles
   initial forever begin
      @(posedge clk_i iff win);
      {ts, tc} = 8'h0;
      repeat (800) begin
         ps = status_led_o;
         pc = config_led_o;
         @(posedge clk_i);
         ts = ts + {3'h0, ps != status_led_o};
         tc = tc + {3'h0, pc != config_led_o};
      end
      `CHK({ts, tc}, tq.pop_front())
   end
   initial begin
      do_reset;
      for (i = 0; i < 2; i++) begin
         powerup_fault_i = 1;
         {fault_num_a_i, fault_num_b_i} = i ? 8'h01 : 8'h2f;
         do_reset;
         gq = i ? '{6'h21, 6'h10, 6'h21} : '{6'h2f, 6'h02, 6'h2f};
         expect_o(58'hd0, 58'h0);
         for (n = 0; gq.size() > 0 && n < 30000; n++) tick(1);
         if (n >= 30000) begin
            fails++;
            stop_test;
         end
      end
      $display("fault blink test done");
      powerup_fault_i = 0;
      do_reset;
      expect_o('1, {32'h0, 16'h4b00, 6'b000111, 4'h0});
      hw_ok_i = 0;
      expect_o(58'h60, 58'h0);
      hw_ok_i = 1;
      // No configuration: config dark, status error alone keeps status steady
      config_valid_i = 0;
      status_err_i = 1;
      expect_o(58'h30, 58'h20);
      status_err_i = 0;
      config_valid_i = 1;
      $display("steady test done");
      for (i = 0; i < 20; i++) begin
         lf = nx(lf);
         {drive_en_i, force_out_i, servo_digital_i, err_log_i, clear_err_i, err_word_i} = lf[8:0];
         err_code_i = lf[23:16];
         baud_cfg_i = i < 4 ? bt[i] : lf[31] ? 16'd300 + 16'(lf[30:16] % 18901) : lf[15:0];
         if (err_log_i) wexp[err_word_i*8 +: 8] = err_code_i;
         merr = err_log_i | (merr & !clear_err_i);
         berr = baud_cfg_i < 300 || baud_cfg_i > 19200;
         if (!berr) be = baud_cfg_i;
         expect_o('1, {wexp, be, berr, servo_digital_i, merr, 3'b111, force_out_i, drive_en_i});
      end
      err_log_i = 0;
      $display("random level test done");
      for (i = 0; i < 6; i++) begin
         {stop_err_i, status_err_i, boot_mode_i, watchdog_to_i, eeprom_write_i, prog_store_i} = mt[i][13:8];
         tick(8);
         tq.push_back(mt[i][7:0]);
         win = 1;
         tick(1);
         win = 0;
         tick(810);
      end
      $display("flash rate test done");
      stop_test;
   end
endmodule
